// File: dv/exc_host_model.sv
// Host controller model that writes and reads the setup register and requests conversions.
`timescale 1ns/1ps
module exc_host_model (
   // Clock.
   input  wire logic       clk,
   // Requests towards the converter.
   output      logic       wr_en,
   output      logic       rd_en,
   output      logic [7:0] addr_ptr,
   output      logic [7:0] wr_data,
   output      logic       conv_start,
   output      logic       conv_is_cap
);
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr_ptr = 8'h00;
      wr_data = 8'h00;
      conv_start = 1'b0;
      conv_is_cap = 1'b0;
   end

   // Callers hand over setup bytes with at most one select per pin
   // and set the clock-halve bit at random in the register test and on purpose for the slow-rate conversion.
   task automatic req(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      wr_en = w;
      rd_en = ~w;
      addr_ptr = a;
      wr_data = d;
      @(negedge clk);
      wr_en = 1'b0;
      rd_en = 1'b0;
      wr_data = ~d;
   endtask

   task automatic start(input logic cap);
      @(negedge clk);
      conv_start = 1'b1;
      conv_is_cap = cap;
      @(negedge clk);
      conv_start = 1'b0;
      conv_is_cap = ~cap;
   endtask
endmodule

// File: dv/exc_setup_ctrl_bench.sv
// Self-checking bench for the excitation setup control.
`timescale 1ns/1ps
module exc_setup_ctrl_bench;
   localparam int CT = 4;
   localparam int MD = 4;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic       wr_en, rd_en, conv_start, conv_is_cap, en, rd_pend;
   logic [7:0] addr_ptr, wr_data, rd_data_q, s, v;
   logic [1:0] drive_level_q;
   logic       rd_hit_q, conv_busy_q, conv_done_q, mod_tick, exc_active_q;
   logic       pin_a_wave_q, pin_a_en_q, pin_b_wave_q, pin_b_en_q;
   logic [8:0] rd_q[$];
   int         cv_q[$];
   int         num_errors = 0, total_checks = 0, cyc = 0, st = 0, ticks = 0, n, seed;
   logic [8:0] tbl[7] = '{9'h108, 9'h028, 9'h068, 9'h114, 9'h118, 9'h124, 9'h198};

   always #10 clk = ~clk;

   exc_setup_ctrl #(.MOD_DIV(16'h0004), .CONV_TICKS(16'h0004)) i_exc_setup_ctrl (
      .clk, .rst, .wr_en, .rd_en, .addr_ptr, .wr_data, .rd_data_q, .rd_hit_q,
      .conv_start, .conv_is_cap, .conv_busy_q, .conv_done_q, .mod_tick,
      .pin_a_wave_q, .pin_a_en_q, .pin_b_wave_q, .pin_b_en_q, .drive_level_q, .exc_active_q);

   exc_host_model i_exc_host_model (
      .clk, .wr_en, .rd_en, .addr_ptr, .wr_data, .conv_start, .conv_is_cap);

   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Tracks the start edge of each accepted conversion and the modulator ticks inside it.
   always @(posedge clk) begin
      cyc++;
      rd_pend <= rd_en;
      if (conv_start && !conv_busy_q) begin
         st = cyc;
         ticks = 0;
      end
      if (conv_busy_q && mod_tick)
         ticks++;
   end

   always @(negedge clk) begin
      if (rd_pend)
         check("read", {rd_hit_q, rd_data_q}, rd_q.pop_front());
      if (conv_done_q) begin
         check("conv_cycles", cyc - st, cv_q.pop_front());
         check("mod_ticks", ticks, CT);
      end
   end

   initial begin
      seed = 43822;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      rd_q.push_back({1'b1, 8'h03});
      i_exc_host_model.req(1'b0, 8'h09, 8'h00);
      rd_q.push_back({1'b0, 8'h00});
      i_exc_host_model.req(1'b0, 8'h0A, 8'h00);
      $display("test reset_value done");
      for (int i = 0; i < 8; i++) begin
         v = 8'($random(seed));
         if (v[3:2] == 2'h3) v[2] = 1'b0;
         if (v[5:4] == 2'h3) v[4] = 1'b0;
         i_exc_host_model.req(1'b1, 8'h09, v);
         i_exc_host_model.req(1'b1, 8'h08, ~v);
         rd_q.push_back({1'b1, v});
         i_exc_host_model.req(1'b0, 8'h09, 8'h00);
         check("level", drive_level_q, v[1:0]);
      end
      $display("test register_rw done");
      for (int k = 0; k < 7; k++) begin
         s = tbl[k][7:0];
         i_exc_host_model.req(1'b1, 8'h09, s);
         cv_q.push_back(CT * MD * (s[7] ? 2 : 1) + 1);
         i_exc_host_model.start(tbl[k][8]);
         if (k == 0)
            i_exc_host_model.start(1'b1);
         repeat (3) @(negedge clk);
         en = tbl[k][8] | s[6];
         check("pin_a_en", pin_a_en_q, en & (|s[3:2]));
         check("pin_b_en", pin_b_en_q, en & (|s[5:4]));
         check("exc_active", exc_active_q, en);
         if (en && (|s[3:2]) && (|s[5:4]))
            check("pin_b_wave", pin_b_wave_q,
                  pin_a_wave_q ^ (s[3:2] == 2'h1) ^ (s[5:4] == 2'h1));
         n = 0;
         while (conv_busy_q === 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
         end
         if (n >= 200) begin
            num_errors++;
            test_done();
         end
         @(negedge clk);
         check("pins_idle", {exc_active_q, pin_a_en_q, pin_b_en_q}, 3'h0);
      end
      $display("test conversions done");
      check("pending", 16'(cv_q.size() + rd_q.size()), 16'h0000);
      test_done();
   end
endmodule

// File: verilog/exc_clkgen.sv
// Modulator tick and excitation waveform generator with selectable halved rate.
`timescale 1ns/1ps
`include "exc_regs.svh"

module exc_clkgen #(
   parameter logic [15:0] MOD_DIV = `EXC_MOD_DIV
) (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst,
   // Control.
   input  wire logic        halve,
   input  wire logic        restart,
   // Outputs.
   output      logic [15:0] period_q,
   output      logic        mod_tick_q,
   output      logic        exc_phase_q
);

   logic [15:0] cnt_q;
   logic [15:0] lim;
   logic [15:0] gap_q;
   logic        halve_seen_q;
   logic        steady_q;

   assign lim = halve ? 16'(MOD_DIV * `EXC_HALVE_FACTOR) : MOD_DIV;

   always_ff @(posedge clk) begin
      if (rst || restart) begin
         cnt_q <= '0;
      end else if (cnt_q >= lim - 16'd1) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 16'd1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || restart) begin
         mod_tick_q <= 1'b0;
      end else begin
         mod_tick_q <= (cnt_q == lim - 16'd1);
      end
   end

   // The excitation waveform flips on every modulator tick, so it follows the same rate.
   always_ff @(posedge clk) begin
      if (rst) begin
         exc_phase_q <= 1'b0;
      end else if (mod_tick_q) begin
         exc_phase_q <= ~exc_phase_q;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         period_q <= MOD_DIV;
      end else begin
         period_q <= lim;
      end
   end

   // Helper counting cycles since the previous tick; a restart counts from zero.
   always_ff @(posedge clk) begin
      if (rst || restart) begin
         gap_q <= '0;
      end else if (mod_tick_q) begin
         gap_q <= 16'h0001;
      end else if (gap_q != 16'hFFFF) begin
         gap_q <= gap_q + 16'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         halve_seen_q <= 1'b0;
      end else begin
         halve_seen_q <= halve;
      end
   end

   // A rate change in mid-period leaves one irregular gap, which the spacing check skips.
   always_ff @(posedge clk) begin
      if (rst || restart) begin
         steady_q <= 1'b1;
      end else if (halve != halve_seen_q) begin
         steady_q <= 1'b0;
      end else if (mod_tick_q) begin
         steady_q <= 1'b1;
      end
   end

   tick_spacing_a: assert property (@(posedge clk) disable iff (rst)
      mod_tick_q && steady_q |-> gap_q == period_q)
      else $error("modulator tick spacing does not match selected rate");

endmodule

// File: verilog/exc_pkg.sv
// Types shared by the excitation setup control.
package exc_pkg;

   typedef struct packed {
      logic       clock_halve_select;
      logic       excitation_always_on;
      logic [1:0] drive_pin_b_select;
      logic [1:0] drive_pin_a_select;
      logic       drive_level_high_bit;
      logic       drive_level_low_bit;
   } exc_setup_t;

   typedef struct packed {
      logic wave;
      logic en;
   } exc_pin_t;

   typedef enum logic {
      EXC_IDLE,
      EXC_RUN
   } exc_state_t;

endpackage

// File: verilog/exc_regs.svh
// Register offsets, reset values and timing counts of the excitation setup control.
// Notes on behaviour
// - Clock-halve bit set slows excitation waveform and modulator clock.
// - Clock-halve bit set doubles every conversion time on all channels.
// - Always-on bit clear: excitation driven only during capacitance conversions.
// - Always-on bit set: excitation driven during capacitance and voltage/temperature conversions.
// - Pin A: bit 3 drives true excitation, bit 2 drives inverted excitation.
// - Pin B: bit 5 true, bit 4 inverted; host sets only one.
// - Setup register sits at pointer 0x09 and resets to 0x03.
`ifndef EXC_REGS_SVH
`define EXC_REGS_SVH

`define EXC_SETUP_ADDR   8'h09
`define EXC_SETUP_RESET  8'h03
`define EXC_READ_IDLE    8'h00
`define EXC_MOD_DIV      16'h0004
`define EXC_CONV_TICKS   16'h0040
`define EXC_HALVE_FACTOR 16'h0002

`endif

// File: verilog/exc_setup_ctrl.sv
// Excitation setup register and excitation pin control for the converter core.
`timescale 1ns/1ps
`include "exc_regs.svh"

module exc_setup_ctrl #(
   parameter logic [15:0] MOD_DIV    = `EXC_MOD_DIV,
   parameter logic [15:0] CONV_TICKS = `EXC_CONV_TICKS
) (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst,
   // Register access from the serial interface.
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   input  wire logic [7:0]  addr_ptr,
   input  wire logic [7:0]  wr_data,
   output      logic [7:0]  rd_data_q,
   output      logic        rd_hit_q,
   // Conversion sequencing.
   input  wire logic        conv_start,
   input  wire logic        conv_is_cap,
   output      logic        conv_busy_q,
   output      logic        conv_done_q,
   output      logic        mod_tick,
   // Excitation pins and level.
   output      logic        pin_a_wave_q,
   output      logic        pin_a_en_q,
   output      logic        pin_b_wave_q,
   output      logic        pin_b_en_q,
   output      logic [1:0]  drive_level_q,
   output      logic        exc_active_q
);

   exc_pkg::exc_setup_t setup_q;
   exc_pkg::exc_state_t state_q;
   exc_pkg::exc_pin_t   pin_a_d;
   exc_pkg::exc_pin_t   pin_b_d;
   logic                is_cap_q;
   logic                halve_q;
   logic [15:0]         tick_cnt_q;
   logic [15:0]         period;
   logic                phase;
   logic                restart;
   logic                last_tick;
   logic                active;
   logic [31:0]         dur_q;

   // Selects the waveform for one pin; the true bit wins if software sets both.
   function automatic exc_pkg::exc_pin_t pin_drive(input logic [1:0] sel,
                                                   input logic       ph,
                                                   input logic       on);
      exc_pkg::exc_pin_t p;
      p.en   = on && (sel != 2'b00);
      p.wave = !on ? 1'b0 : (sel[1] ? ph : (sel[0] ? ~ph : 1'b0));
      return p;
   endfunction

   // Setup register.
   always_ff @(posedge clk) begin
      if (rst) begin
         setup_q <= exc_pkg::exc_setup_t'(`EXC_SETUP_RESET);
      end else if (wr_en && addr_ptr == `EXC_SETUP_ADDR) begin
         setup_q <= exc_pkg::exc_setup_t'(wr_data);
      end
   end

   // Read port; other pointers belong to neighbouring registers and read as idle.
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data_q <= `EXC_READ_IDLE;
         rd_hit_q  <= 1'b0;
      end else if (rd_en) begin
         rd_hit_q  <= (addr_ptr == `EXC_SETUP_ADDR);
         rd_data_q <= (addr_ptr == `EXC_SETUP_ADDR) ? 8'(setup_q) : `EXC_READ_IDLE;
      end else begin
         rd_hit_q  <= 1'b0;
      end
   end

   // The rate is frozen during a conversion so its length stays exact.
   always_ff @(posedge clk) begin
      if (rst) begin
         halve_q <= 1'b0;
      end else if (state_q == exc_pkg::EXC_IDLE) begin
         halve_q <= setup_q.clock_halve_select;
      end
   end

   assign restart   = (state_q == exc_pkg::EXC_IDLE) && conv_start;
   assign last_tick = (state_q == exc_pkg::EXC_RUN) && mod_tick
                      && (tick_cnt_q == CONV_TICKS - 16'd1);

   exc_clkgen #(
      .MOD_DIV (MOD_DIV)
   ) u_clkgen (
      .clk         (clk),
      .rst         (rst),
      .halve       (restart ? setup_q.clock_halve_select : halve_q),
      .restart     (restart),
      .period_q    (period),
      .mod_tick_q  (mod_tick),
      .exc_phase_q (phase)
   );

   // Conversion sequencer; length is counted in modulator ticks.
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= exc_pkg::EXC_IDLE;
      end else begin
         case (state_q)
            exc_pkg::EXC_IDLE: begin
               if (conv_start) begin
                  state_q <= exc_pkg::EXC_RUN;
               end
            end
            exc_pkg::EXC_RUN: begin
               if (last_tick) begin
                  state_q <= exc_pkg::EXC_IDLE;
               end
            end
            default: begin
               state_q <= exc_pkg::EXC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tick_cnt_q <= '0;
      end else if (restart) begin
         tick_cnt_q <= '0;
      end else if (state_q == exc_pkg::EXC_RUN && mod_tick) begin
         tick_cnt_q <= tick_cnt_q + 16'd1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         is_cap_q <= 1'b0;
      end else if (restart) begin
         is_cap_q <= conv_is_cap;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         conv_busy_q <= 1'b0;
         conv_done_q <= 1'b0;
      end else begin
         conv_busy_q <= restart || (conv_busy_q && !last_tick);
         conv_done_q <= last_tick;
      end
   end

   // Excitation is gated by the conversion kind and the always-on bit.
   assign active = (state_q == exc_pkg::EXC_RUN)
                   && (is_cap_q || setup_q.excitation_always_on);

   always_comb begin
      pin_a_d = pin_drive(setup_q.drive_pin_a_select, phase, active);
      pin_b_d = pin_drive(setup_q.drive_pin_b_select, phase, active);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_a_wave_q <= 1'b0;
         pin_a_en_q   <= 1'b0;
         pin_b_wave_q <= 1'b0;
         pin_b_en_q   <= 1'b0;
         exc_active_q <= 1'b0;
      end else begin
         pin_a_wave_q <= pin_a_d.wave;
         pin_a_en_q   <= pin_a_d.en;
         pin_b_wave_q <= pin_b_d.wave;
         pin_b_en_q   <= pin_b_d.en;
         exc_active_q <= active;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         drive_level_q <= '0;
      end else begin
         drive_level_q <= {setup_q.drive_level_high_bit, setup_q.drive_level_low_bit};
      end
   end

   // Helper counting cycles of the running conversion.
   always_ff @(posedge clk) begin
      if (rst || restart) begin
         dur_q <= '0;
      end else if (state_q == exc_pkg::EXC_RUN) begin
         dur_q <= dur_q + 32'd1;
      end
   end

   reset_value_a: assert property (@(posedge clk)
      rst |=> 8'(setup_q) == `EXC_SETUP_RESET)
      else $error("setup register not at reset value");

   setup_read_a: assert property (@(posedge clk) disable iff (rst)
      rd_en && !wr_en && addr_ptr == `EXC_SETUP_ADDR |=> rd_hit_q
      && rd_data_q == $past(8'(setup_q)))
      else $error("read of setup register returned wrong value");

   conv_length_a: assert property (@(posedge clk) disable iff (rst)
      last_tick |-> dur_q == 32'(CONV_TICKS) * 32'(period))
      else $error("conversion length does not match tick rate");

   halve_double_a: assert property (@(posedge clk) disable iff (rst)
      state_q == exc_pkg::EXC_RUN && halve_q |-> period == 16'(MOD_DIV * `EXC_HALVE_FACTOR))
      else $error("halved rate not applied during conversion");

   cap_only_a: assert property (@(posedge clk) disable iff (rst)
      !setup_q.excitation_always_on && !is_cap_q |=> !pin_a_en_q && !pin_b_en_q)
      else $error("excitation driven outside capacitance conversion");

   always_on_a: assert property (@(posedge clk) disable iff (rst)
      state_q == exc_pkg::EXC_RUN && setup_q.excitation_always_on
      && setup_q.drive_pin_a_select != 2'b00 |=> pin_a_en_q)
      else $error("always-on excitation missing on pin A");

   pin_a_wave_a: assert property (@(posedge clk) disable iff (rst)
      active && setup_q.drive_pin_a_select == 2'b01 |=> pin_a_wave_q == ~$past(phase))
      else $error("pin A inverted waveform wrong");

   pin_b_wave_a: assert property (@(posedge clk) disable iff (rst)
      active && setup_q.drive_pin_b_select == 2'b10 |=> pin_b_en_q
      && pin_b_wave_q == $past(phase))
      else $error("pin B true waveform wrong");

endmodule
